// [fcw_consts.vh]
`ifndef FCW_CONSTS_VH
`define FCW_CONSTS_VH

// printed word locations (2088h aside, not multiples of four): kept as indices, byte address = 4 * index
`define FCW_IDX_OUTCMP       16'h2086
`define FCW_IDX_DIODE        16'h2087
`define FCW_IDX_HSSENSE      16'h2088
`define FCW_IDX_TEMPREF      16'h2089

// word width
`define FCW_WORD_W           14

// output comparator word fields
`define FCW_UV_MSB           7
`define FCW_UV_LSB           4
`define FCW_OV_MSB           3
`define FCW_OV_LSB           0

// single-field words
`define FCW_DIODE_MSB        4
`define FCW_HSS_MSB          6
`define FCW_TEMP_MSB         9

// erased factory value: all programmable bits set
`define FCW_ERASED_WORD      14'h3fff

// axi response codes
`define FCW_RESP_OKAY        2'h0
`define FCW_RESP_SLVERR      2'h2

`endif

// [fcw_word_mask.v]
`timescale 1ns/1ns
`default_nettype none

// clears every bit above the implemented field of one stored word
module fcw_word_mask #(
  parameter WIDTH  = 14,
  parameter FIELDW = 4
) (
  // raw word
  input  wire [WIDTH-1:0] rawWord,
  // masked word
  output wire [WIDTH-1:0] maskedWord
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      assign maskedWord[i] = (i < FIELDW) ? rawWord[i] : 1'b0;
    end
  endgenerate

endmodule

`default_nettype wire

// [fcw_calib_store.v]
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
`include "fcw_consts.vh"

//Contract
//- the output comparator word is a 14-bit read-only word at index 2086h.
//- that word carries the undervoltage comparator trim in bits 7-4.
//- that word carries the overvoltage comparator trim in bits 3-0, with bits 13-8 unused.
//- every unimplemented bit of the calibration words reads as zero whatever was programmed.
//- the diode emulation trim sits in bits 4-0 of the word at index 2087h, bits 13-5 zero.
//- the high side sense trim sits in bits 6-0 of the word at index 2088h, bits 13-7 zero.
//- index 2089h holds the 10-bit temperature sensor reading taken at +25 C.
module fcw_calib_store #(
  parameter ADDR_W = 16
) (
  // clock and reset
  input  wire              clk_sys,
  input  wire              arst_n,
  // factory programmed contents
  input  wire [13:0]       factOutCmpWord,
  input  wire [13:0]       factDiodeWord,
  input  wire [13:0]       factHsSenseWord,
  input  wire [13:0]       factTempRefWord,
  // write address channel
  input  wire [ADDR_W-1:0] s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output wire              s_axi_awready,
  // write data channel
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output wire              s_axi_wready,
  // write response channel
  output wire [1:0]        s_axi_bresp,
  output wire              s_axi_bvalid,
  input  wire              s_axi_bready,
  // read address channel
  input  wire [ADDR_W-1:0] s_axi_araddr,
  input  wire              s_axi_arvalid,
  output wire              s_axi_arready,
  // read data channel
  output wire [31:0]       s_axi_rdata,
  output wire [1:0]        s_axi_rresp,
  output wire              s_axi_rvalid,
  input  wire              s_axi_rready,
  // trim fields toward the analog trim registers
  output wire [3:0]        undervoltageComparatorTrim,
  output wire [3:0]        overvoltageComparatorTrim,
  output wire [4:0]        diodeEmulationTrim,
  output wire [6:0]        highSideSenseTrim,
  output wire [9:0]        temperatureReferenceValue,
  output wire              calibLoaded
);

  // byte address is four times the word index
  localparam [ADDR_W-1:0] ADDR_OUTCMP  = `FCW_IDX_OUTCMP << 2;
  localparam [ADDR_W-1:0] ADDR_DIODE   = `FCW_IDX_DIODE << 2;
  localparam [ADDR_W-1:0] ADDR_HSSENSE = `FCW_IDX_HSSENSE << 2;
  localparam [ADDR_W-1:0] ADDR_TEMPREF = `FCW_IDX_TEMPREF << 2;

  // stored words, sampled once after reset release
  reg  [13:0] outCmpWord_reg;
  reg  [13:0] diodeWord_reg;
  reg  [13:0] hsSenseWord_reg;
  reg  [13:0] tempRefWord_reg;
  reg         loaded_reg;
  wire [13:0] outCmpMasked;
  wire [13:0] diodeMasked;
  wire [13:0] hsSenseMasked;
  wire [13:0] tempRefMasked;

  // implemented bits only
  fcw_word_mask #(.WIDTH(14), .FIELDW(8)) uOutCmpMask (
    .rawWord    (factOutCmpWord),
    .maskedWord (outCmpMasked)
  );
  fcw_word_mask #(.WIDTH(14), .FIELDW(5)) uDiodeMask (
    .rawWord    (factDiodeWord),
    .maskedWord (diodeMasked)
  );
  fcw_word_mask #(.WIDTH(14), .FIELDW(7)) uHsMask (
    .rawWord    (factHsSenseWord),
    .maskedWord (hsSenseMasked)
  );
  fcw_word_mask #(.WIDTH(14), .FIELDW(10)) uTempMask (
    .rawWord    (factTempRefWord),
    .maskedWord (tempRefMasked)
  );

  // capture at the first edge after release, read-only afterwards
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      outCmpWord_reg  <= 14'h0000;
      diodeWord_reg   <= 14'h0000;
      hsSenseWord_reg <= 14'h0000;
      tempRefWord_reg <= 14'h0000;
      loaded_reg      <= 1'b0;
    end else if (!loaded_reg) begin
      outCmpWord_reg  <= outCmpMasked;
      diodeWord_reg   <= diodeMasked;
      hsSenseWord_reg <= hsSenseMasked;
      tempRefWord_reg <= tempRefMasked;
      loaded_reg      <= 1'b1;
    end
  end

  assign undervoltageComparatorTrim = outCmpWord_reg[`FCW_UV_MSB:`FCW_UV_LSB];
  assign overvoltageComparatorTrim  = outCmpWord_reg[`FCW_OV_MSB:`FCW_OV_LSB];
  assign diodeEmulationTrim         = diodeWord_reg[`FCW_DIODE_MSB:0];
  assign highSideSenseTrim          = hsSenseWord_reg[`FCW_HSS_MSB:0];
  assign temperatureReferenceValue  = tempRefWord_reg[`FCW_TEMP_MSB:0];
  assign calibLoaded                = loaded_reg;

  // write path: accepted and refused, the words are read-only
  reg awTaken_reg;
  reg wTaken_reg;
  reg bValid_reg;

  assign s_axi_awready = !awTaken_reg && !bValid_reg;
  assign s_axi_wready  = !wTaken_reg && !bValid_reg;
  assign s_axi_bvalid  = bValid_reg;
  assign s_axi_bresp   = `FCW_RESP_SLVERR;

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      awTaken_reg <= 1'b0;
      wTaken_reg  <= 1'b0;
      bValid_reg  <= 1'b0;
    end else begin
      if (bValid_reg) begin
        if (s_axi_bready) begin
          bValid_reg <= 1'b0;
        end
      end else begin
        if ((awTaken_reg || s_axi_awvalid) && (wTaken_reg || s_axi_wvalid)) begin
          bValid_reg  <= 1'b1;
          awTaken_reg <= 1'b0;
          wTaken_reg  <= 1'b0;
        end else begin
          if (s_axi_awvalid) begin
            awTaken_reg <= 1'b1;
          end
          if (s_axi_wvalid) begin
            wTaken_reg <= 1'b1;
          end
        end
      end
    end
  end

  // read path
  reg        rValid_reg;
  reg [31:0] rData_reg;
  reg [1:0]  rResp_reg;
  reg [31:0] rData_next;
  reg [1:0]  rResp_next;

  assign s_axi_arready = !rValid_reg;
  assign s_axi_rvalid  = rValid_reg;
  assign s_axi_rdata   = rData_reg;
  assign s_axi_rresp   = rResp_reg;

  always @* begin
    rData_next = 32'h00000000;
    rResp_next = `FCW_RESP_OKAY;
    case (s_axi_araddr)
      ADDR_OUTCMP: begin
        rData_next = {18'h00000, outCmpWord_reg};
      end
      ADDR_DIODE: begin
        rData_next = {18'h00000, diodeWord_reg};
      end
      ADDR_HSSENSE: begin
        rData_next = {18'h00000, hsSenseWord_reg};
      end
      ADDR_TEMPREF: begin
        rData_next = {18'h00000, tempRefWord_reg};
      end
      default: begin
        rResp_next = `FCW_RESP_SLVERR;
      end
    endcase
  end

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rValid_reg <= 1'b0;
      rData_reg  <= 32'h00000000;
      rResp_reg  <= `FCW_RESP_OKAY;
    end else if (rValid_reg) begin
      if (s_axi_rready) begin
        rValid_reg <= 1'b0;
      end
    end else if (s_axi_arvalid) begin
      rValid_reg <= 1'b1;
      rData_reg  <= rData_next;
      rResp_reg  <= rResp_next;
    end
  end

  // unused write payload
  wire unusedWrite = ^{s_axi_wdata, s_axi_wstrb, s_axi_awaddr};

endmodule

`default_nettype wire

// [fcw_calib_store_sva.sv]
`timescale 1ns/1ns
`default_nettype none
module fcw_calib_store_sva (
  input wire logic        clk_sys, arst_n, calibLoaded,
  input wire logic [13:0] factOutCmpWord, factDiodeWord, factHsSenseWord, factTempRefWord,
  input wire logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, s_axi_bvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp, s_axi_bresp,
  input wire logic [3:0]  undervoltageComparatorTrim, overvoltageComparatorTrim,
  input wire logic [4:0]  diodeEmulationTrim,
  input wire logic [6:0]  highSideSenseTrim,
  input wire logic [9:0]  temperatureReferenceValue
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  a_uv_field:
    assert property (calibLoaded |-> undervoltageComparatorTrim == factOutCmpWord[7:4])
    else $error("uv trim wrong");
  a_ov_field:
    assert property (calibLoaded |-> overvoltageComparatorTrim == factOutCmpWord[3:0])
    else $error("ov trim wrong");
  a_diode_field:
    assert property (calibLoaded |-> diodeEmulationTrim == factDiodeWord[4:0])
    else $error("diode trim wrong");
  a_hss_field:
    assert property (calibLoaded |-> highSideSenseTrim == factHsSenseWord[6:0])
    else $error("sense trim wrong");
  a_temp_field:
    assert property (calibLoaded |-> temperatureReferenceValue == factTempRefWord[9:0])
    else $error("temp value wrong");
  a_upper_zero:
    assert property (s_axi_rvalid |-> s_axi_rdata[31:14] == 18'h0)
    else $error("upper bits set");
  a_read_answer:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  a_write_refused:
    assert property (s_axi_bvalid |-> s_axi_bresp == 2'h2)
    else $error("write accepted");
  cover property (s_axi_rvalid && s_axi_rready && s_axi_rresp == 2'h0);
  cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
  cover property (s_axi_bvalid);
endmodule
bind fcw_calib_store fcw_calib_store_sva i_sva (.*);
`default_nettype wire

// [fcw_calib_store_bench.sv]
`timescale 1ns/1ns
`default_nettype none
module fcw_calib_store_bench;
  logic        clk_sys = 0, arst_n = 0, calibLoaded;
  logic [13:0] factOutCmpWord = 14'h3ea5, factDiodeWord = 14'h2a76;
  logic [13:0] factHsSenseWord = 14'h15d9, factTempRefWord = 14'h3b6e;
  logic [15:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb = 4'hf, undervoltageComparatorTrim, overvoltageComparatorTrim;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [4:0]  diodeEmulationTrim;
  logic [6:0]  highSideSenseTrim;
  logic [9:0]  temperatureReferenceValue;
  int          fails = 0, checks_done = 0;
  logic [15:0] rowA [5] = '{16'h8218, 16'h821c, 16'h8220, 16'h8224, 16'h8228};
  logic [31:0] rowD [5] = '{32'ha5, 32'h16, 32'h59, 32'h36e, 32'h0};
  logic [1:0]  rowR [5] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h2};
  fcw_calib_store i_dut (.*);
  always #25 clk_sys = ~clk_sys;
  task automatic chk(input logic [31:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic axiRd(input logic [15:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do @(posedge clk_sys); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    do @(posedge clk_sys); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 0;
    @(posedge clk_sys);
  endtask
  task automatic axiWr(input logic [15:0] a, input logic [31:0] v);
    logic aw, w;
    aw = 1;
    w = 1;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (aw || w) begin
      @(posedge clk_sys);
      if (aw && s_axi_awready) begin
        aw = 0;
        s_axi_awvalid <= 0;
      end
      if (w && s_axi_wready) begin
        w = 0;
        s_axi_wvalid <= 0;
      end
    end
    do @(posedge clk_sys); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 0;
    @(posedge clk_sys);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk_sys);
    arst_n <= 1;
    repeat (2) @(posedge clk_sys);
    for (int i = 0; i < 5; i++) begin
      axiRd(rowA[i]);
      chk(d, rowD[i]);
      chk(r, rowR[i]);
    end
    chk({undervoltageComparatorTrim, overvoltageComparatorTrim}, 32'ha5);
    chk(diodeEmulationTrim, 32'h16);
    chk(highSideSenseTrim, 32'h59);
    chk(temperatureReferenceValue, 32'h36e);
    $display("table test done");
    axiWr(16'h8218, 32'h0);
    chk(r, 32'h2);
    axiRd(16'h8218);
    chk(d, 32'ha5);
    $display("write refusal test done");
    arst_n <= 0;
    @(posedge clk_sys);
    chk({calibLoaded, temperatureReferenceValue}, 32'h0);
    chk({s_axi_awready, s_axi_wready, s_axi_arready}, 32'h7);
    arst_n <= 1;
    repeat (2) @(posedge clk_sys);
    axiRd(16'h8224);
    chk(d, 32'h36e);
    $display("reset test done");
    report_and_stop();
  end
  initial begin
    repeat (2000) @(posedge clk_sys);
    fails++;
    report_and_stop();
  end
endmodule
`default_nettype wire
